// ==== verilog/cspc_top.v ====
/*
 global clock select and E1 arbitrary pulse enable register with its
 effect on the four channel transmitters and the clock synthesizer.
 assumes a synchronous 8-bit host register port on CLK_SYS.
*/
`timescale 1ns/1ps
`include "cspc_regs.vh"
// Operation
// R1 - host splits clock-select and other-bit changes into two writes
// R2 - host treats D6..D3 and D7,D2..D0 as independent sub-registers
// R3 - either write order yields the same final configuration
// R4 - enable bit set in E1 puts every transmitter in arbitrary mode
// R5 - in arbitrary mode each channel uses its own segment registers
// R6 - enable bit clear gives the standard fixed E1 pulse
// R7 - writing clock-select or rate bits retunes the multiplier; code retunes only when the written D6..D3 value differs
// R8 - select 000 means 2048 kHz in, 001 1544 kHz; rate 0/1 = 2048/1544
module cspc_top
#(
	parameter CHANNELS = 4,
	parameter SETTLE = 16
)
(
	// clock and reset
	input wire CLK_SYS,
	input wire RSTN,
	// register port
	input wire [6:0] ADDR,
	input wire WR,
	input wire RD,
	input wire [7:0] WDATA,
	output reg [7:0] RDATA,
	// line mode, E1 when high
	input wire E1_MODE,
	// per-channel transmit shaping
	output reg [CHANNELS-1:0] TX_ARB_MODE,
	output reg [CHANNELS-1:0] TX_USE_SEGMENTS,
	// synthesizer control
	output reg [2:0] SYNTH_INPUT_SELECT,
	output reg MASTER_RATE_SELECT,
	output reg SYNTH_CLOCK_1544,
	output reg SYNTH_RETUNING
);
	// field places inside the four-bit clock group
	localparam GRP_SEL_HI = `CSPC_SEL_HI - `CSPC_CLK_LO;
	localparam GRP_SEL_LO = `CSPC_SEL_LO - `CSPC_CLK_LO;
	localparam GRP_RATE = `CSPC_BIT_RATE - `CSPC_CLK_LO;
	// reset image of the whole byte, sliced per sub-register
	localparam [7:0] CFG_RST = `CSPC_CFG_RST;

	// enable sub-register, D7
	reg arb_en_r;
	reg arb_en_nxt;
	// clock group sub-register, D6..D3
	reg [3:0] clk_grp_r;
	reg [3:0] clk_grp_nxt;
	// low bits D2..D0, kept for readback only
	reg [2:0] spare_r;
	reg [2:0] spare_nxt;
	// line mode synchroniser stages
	reg e1_s1_r;
	reg e1_s2_r;
	// one-cycle retune request to the sequencer
	reg load_r;
	reg load_nxt;
	// decoded host access
	wire wr_hit;
	wire rd_hit;
	wire [3:0] wr_clk_grp;
	// byte as seen on readback
	wire [7:0] cfg_byte;
	// global arbitrary enable qualified by line mode
	wire arb_on;
	// setting applied by the sequencer
	wire [2:0] sel_app;
	wire rate_app;
	wire busy;

	// true when the host addresses the configuration register
	function cfg_addr_hit;
		input [`CSPC_ADDR_W-1:0] addr;
	begin
		cfg_addr_hit = (addr == `CSPC_ADDR_CFG);
	end
	endfunction

	// clock group of a register byte, bits 6 down to 3
	function [3:0] clk_field;
		input [7:0] cfg;
	begin
		clk_field = cfg[`CSPC_CLK_HI:`CSPC_CLK_LO];
	end
	endfunction

	// host strobes qualified by the address decode
	assign wr_hit = WR && cfg_addr_hit(ADDR);
	assign rd_hit = RD && cfg_addr_hit(ADDR);
	assign wr_clk_grp = clk_field(WDATA);

	// enable sub-register takes its own slice of every write
	always @*
	begin
		arb_en_nxt = arb_en_r;
		if (wr_hit)
			arb_en_nxt = WDATA[`CSPC_BIT_ARB]; // R3
	end

	// clock group takes its slice; same result in either write order
	always @*
	begin
		clk_grp_nxt = clk_grp_r;
		if (wr_hit)
			clk_grp_nxt = wr_clk_grp; // R3
	end

	// low bits have no effect here, only stored
	always @*
	begin
		spare_nxt = spare_r;
		if (wr_hit)
			spare_nxt = WDATA[`CSPC_CLK_LO-1:0];
	end

	// rewriting the same clock code must not disturb the multiplier
	always @*
	begin
		load_nxt = 1'b0;
		if (clk_grp_nxt != clk_grp_r)
			load_nxt = 1'b1; // R7
	end

	// sub-registers and retune request
	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			arb_en_r <= CFG_RST[`CSPC_BIT_ARB];
			clk_grp_r <= CFG_RST[`CSPC_CLK_HI:`CSPC_CLK_LO];
			spare_r <= CFG_RST[`CSPC_CLK_LO-1:0];
			load_r <= 1'b0;
		end
		else
		begin
			arb_en_r <= arb_en_nxt;
			clk_grp_r <= clk_grp_nxt;
			spare_r <= spare_nxt;
			load_r <= load_nxt;
		end
	end

	// line mode pin is asynchronous; only the second stage is used
	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			e1_s1_r <= 1'b0;
			e1_s2_r <= 1'b0;
		end
		else
		begin
			e1_s1_r <= E1_MODE;
			e1_s2_r <= e1_s1_r;
		end
	end

	// readback image of the stored byte
	assign cfg_byte = {arb_en_r, clk_grp_r, spare_r};

	// retune sequencer holds the applied setting
	cspc_synth_ctrl #(.SETTLE(SETTLE)) u_synth
	(
		.clk(CLK_SYS),
		.rst_n(RSTN),
		.sel_in(clk_grp_r[GRP_SEL_HI:GRP_SEL_LO]),
		.rate_in(clk_grp_r[GRP_RATE]),
		.load(load_r),
		.sel_r(sel_app),
		.rate_r(rate_app),
		.busy_r(busy)
	);

	// arbitrary shaping only counts while the line runs E1
	assign arb_on = arb_en_r & e1_s2_r; // R4 R6

	// read data stands one cycle per read, zero otherwise
	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			RDATA <= 8'h00;
		else if (rd_hit)
			RDATA <= cfg_byte;
		else
			RDATA <= 8'h00;
	end

	// every channel follows the one global enable
	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			TX_ARB_MODE <= {CHANNELS{1'b0}};
			TX_USE_SEGMENTS <= {CHANNELS{1'b0}};
		end
		else
		begin
			TX_ARB_MODE <= {CHANNELS{arb_on}}; // R4
			TX_USE_SEGMENTS <= {CHANNELS{arb_on}}; // R5
		end
	end

	// applied synthesizer setting and the output rate it gives
	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
		begin
			SYNTH_INPUT_SELECT <= `CSPC_SEL_2048;
			MASTER_RATE_SELECT <= `CSPC_RATE_2048;
			SYNTH_CLOCK_1544 <= 1'b0;
		end
		else
		begin
			SYNTH_INPUT_SELECT <= sel_app; // R8
			MASTER_RATE_SELECT <= rate_app;
			SYNTH_CLOCK_1544 <= (rate_app == `CSPC_RATE_1544); // R8
		end
	end

	// retune flag covers the request cycle and the settle time
	always @(posedge CLK_SYS or negedge RSTN)
	begin
		if (!RSTN)
			SYNTH_RETUNING <= 1'b0;
		else
			SYNTH_RETUNING <= busy | load_r; // R7
	end
endmodule

// ==== verilog/cspc_regs.vh ====
/*
 global clock and pulse configuration register: offset, field positions,
 reset value and synthesizer codes; assumes an 8-bit register port.
*/
`ifndef CSPC_REGS_VH
`define CSPC_REGS_VH
`define CSPC_ADDR_CFG 7'h41
`define CSPC_ADDR_W 7
`define CSPC_BIT_ARB 7
`define CSPC_SEL_HI 6
`define CSPC_SEL_LO 4
`define CSPC_BIT_RATE 3
`define CSPC_CLK_HI 6
`define CSPC_CLK_LO 3
`define CSPC_CFG_RST 8'h00
`define CSPC_SEL_2048 3'h0
`define CSPC_SEL_1544 3'h1
`define CSPC_RATE_2048 1'b0
`define CSPC_RATE_1544 1'b1
`define CSPC_SETTLE_CYC 16'h0010
`endif

// ==== verilog/cspc_synth_ctrl.v ====
/*
 synthesizer retune sequencer: holds the multiplier settings and a busy
 flag for a fixed settle time after each change; assumes one clock.
*/
`timescale 1ns/1ps
`include "cspc_regs.vh"
module cspc_synth_ctrl
#(
	parameter SETTLE = 16
)
(
	// clock and reset
	input wire clk,
	input wire rst_n,
	// requested setting
	input wire [2:0] sel_in,
	input wire rate_in,
	input wire load,
	// applied setting
	output reg [2:0] sel_r,
	output reg rate_r,
	output reg busy_r
);
	reg [15:0] cnt_r;

	// latch new setting and run the settle counter
	always @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			sel_r <= 3'h0;
			rate_r <= 1'b0;
			busy_r <= 1'b0;
			cnt_r <= 16'h0000;
		end
		else if (load)
		begin
			sel_r <= sel_in;
			rate_r <= rate_in;
			busy_r <= (SETTLE != 0);
			cnt_r <= SETTLE[15:0];
		end
		else if (cnt_r != 16'h0000)
		begin
			cnt_r <= cnt_r - 16'h0001;
			busy_r <= (cnt_r != 16'h0001);
		end
	end
endmodule

// ==== sim/cspc_asserts.sv ====
/*
 checker for the configuration register outputs; assumes the top ports
 only and writes spaced so each walk completes.
*/
`timescale 1ns/1ps
module cspc_asserts
#(parameter CHANNELS = 4, parameter SETTLE = 16)
(
	// clock and reset
	input wire CLK_SYS,
	input wire RSTN,
	// register port
	input wire [6:0] ADDR,
	input wire WR,
	input wire RD,
	input wire [7:0] WDATA,
	input wire [7:0] RDATA,
	// line mode
	input wire E1_MODE,
	// channel shaping
	input wire [CHANNELS-1:0] TX_ARB_MODE,
	input wire [CHANNELS-1:0] TX_USE_SEGMENTS,
	// synthesizer
	input wire [2:0] SYNTH_INPUT_SELECT,
	input wire MASTER_RATE_SELECT,
	input wire SYNTH_CLOCK_1544,
	input wire SYNTH_RETUNING
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	// shadow copy of the stored byte
	wire w = WR && ADDR == 7'h41;
	reg [7:0] c_r;
	always @(posedge CLK_SYS or negedge RSTN)
		if (!RSTN) c_r <= 8'h00;
		else if (w) c_r <= WDATA;
	a_arb_mode: assert property (w && WDATA[7] && $past(E1_MODE)
		&& $past(RSTN, 3) ##1 !w |-> ##1 &TX_ARB_MODE)
		else $error("arbitrary mode missing");
	a_seg_same: assert property (TX_USE_SEGMENTS == TX_ARB_MODE)
		else $error("segment use differs");
	a_std_shape: assert property (w && !WDATA[7] ##1 !w
		|-> ##1 TX_ARB_MODE == 0) else $error("fixed shape missing");
	a_synth_apply: assert property (w ##1 !w [*2] |-> ##1
		SYNTH_INPUT_SELECT == $past(WDATA[6:4], 3)
		&& MASTER_RATE_SELECT == $past(WDATA[3], 3)) else $error("synth");
	a_rate_clock: assert property (SYNTH_CLOCK_1544 == MASTER_RATE_SELECT)
		else $error("output rate");
	a_retune_start: assert property (w && WDATA[6:3] != c_r[6:3]
		|-> ##2 SYNTH_RETUNING) else $error("no retune");
	cover property (w && WDATA[7] && E1_MODE);
	cover property ($rose(SYNTH_RETUNING));
	cover property (SYNTH_CLOCK_1544);
endmodule
bind cspc_top cspc_asserts #(.CHANNELS(CHANNELS), .SETTLE(SETTLE)) i_chk (.*);

// ==== sim/tb_clock_synth_pulse_config.sv ====
/*
 testbench for the configuration register; assumes SETTLE of 4.
*/
`timescale 1ns/1ps
module tb_clock_synth_pulse_config;
	reg clk = 0, rstn = 0, wr_en = 0, rd = 0, e1 = 1;
	reg [6:0] a = 0;
	reg [7:0] d = 0;
	wire [7:0] q;
	wire [3:0] arb, seg;
	wire [2:0] sel;
	wire rate, c1544, rt;
	integer miscompares = 0, checks = 0, i;
	cspc_top #(.SETTLE(4)) i_dut (.CLK_SYS(clk), .RSTN(rstn), .ADDR(a),
		.WR(wr_en), .RD(rd), .WDATA(d), .RDATA(q), .E1_MODE(e1),
		.TX_ARB_MODE(arb), .TX_USE_SEGMENTS(seg), .SYNTH_INPUT_SELECT(sel),
		.MASTER_RATE_SELECT(rate), .SYNTH_CLOCK_1544(c1544),
		.SYNTH_RETUNING(rt));
	initial forever #5 clk = ~clk;
	task ck(input [63:0] n, input [7:0] e, input [7:0] s);
	begin
		checks = checks + 1;
		if (e !== s)
		begin
			miscompares = miscompares + 1;
			$display("Error %0s exp %h got %h", n, e, s);
		end
	end
	endtask
	task wr(input [6:0] x, input [7:0] y);
	begin
		@(negedge clk);
		a = x;
		d = y;
		wr_en = 1;
		@(negedge clk);
		wr_en = 0;
	end
	endtask
	task rdc(input [6:0] x, input [7:0] e);
	begin
		@(negedge clk);
		a = x;
		rd = 1;
		@(negedge clk);
		ck("rdata", e, q);
		rd = 0;
	end
	endtask
	task final_report;
	begin
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	end
	endtask
	// bounded wait for the retune flag to drop
	task wait_idle;
	begin
		for (i = 0; i < 20 && rt === 1'b1; i = i + 1) @(negedge clk);
		if (i == 20)
		begin
			miscompares = miscompares + 1;
			$display("Error retune_end exp 0 got 1");
			final_report;
		end
	end
	endtask
	// reset value, unmapped place, line mode effect
	task t_arb;
	begin
		rdc(7'h41, 8'h00);
		wr(7'h40, 8'hff);
		rdc(7'h40, 8'h00);
		rdc(7'h41, 8'h00);
		wr(7'h41, 8'h80);
		repeat (2) @(negedge clk);
		ck("arb", 8'h0f, arb);
		ck("seg", 8'h0f, seg);
		e1 = 0;
		repeat (4) @(negedge clk);
		ck("arb_t1", 8'h00, arb);
		e1 = 1;
		wr(7'h41, 8'h00);
		repeat (4) @(negedge clk);
		ck("arb_off", 8'h00, arb);
		$display("arb done");
	end
	endtask
	// both split orders reach one result
	task t_order;
	begin
		wr(7'h41, 8'h18);
		wr(7'h41, 8'h98);
		repeat (3) @(negedge clk);
		rdc(7'h41, 8'h98);
		ck("sel", 8'h01, sel);
		ck("arb", 8'h0f, arb);
		wr(7'h41, 8'h18);
		wr(7'h41, 8'h00);
		wr(7'h41, 8'h80);
		wr(7'h41, 8'h98);
		repeat (3) @(negedge clk);
		rdc(7'h41, 8'h98);
		ck("sel", 8'h01, sel);
		ck("arb", 8'h0f, arb);
		$display("order done");
	end
	endtask
	// input codes 000 and 001 with both rates, then the retune window
	task t_codes;
	begin
		wr(7'h41, 8'h18);
		for (i = 0; i < 4; i = i + 1)
		begin
			wr(7'h41, {3'h0, i[1], i[0], 3'h0});
			repeat (3) @(negedge clk);
			ck("sel", i[1], sel);
			ck("rate", i[0], rate);
			ck("clk1544", i[0], c1544);
		end
		wait_idle;
		wr(7'h41, 8'h00);
		repeat (2) @(negedge clk);
		ck("retune", 8'h01, rt);
		wait_idle;
		wr(7'h41, 8'h87);
		repeat (2) @(negedge clk);
		ck("retune", 8'h00, rt);
		rdc(7'h41, 8'h87);
		$display("codes done");
	end
	endtask
	initial
	begin
		repeat (5) @(negedge clk);
		rstn = 1;
		t_arb;
		t_order;
		t_codes;
		final_report;
	end
endmodule
